// ===== sfc_map.svh
/*
  Register offsets, field positions, reset values and limits of the sample
  buffer control block. Included by the FIFO, delay counter and control files; holds definitions only.
*/
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SFC_ADDR_PRESS_HI  8'h01
`define SFC_ADDR_OUT_LAST  8'h05
`define SFC_ADDR_BUF_DATA  8'h0E
`define SFC_ADDR_SETUP     8'h0F
`define SFC_ADDR_DELAY     8'h10
`define SFC_ADDR_SYSMODE   8'h11

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define SFC_MODE_MSB       7
`define SFC_MODE_LSB       6
`define SFC_WMRK_MSB       5
`define SFC_WMRK_LSB       0
`define SFC_MODE_OFF       2'h0
`define SFC_MODE_CIRC      2'h1
`define SFC_MODE_STOP      2'h2
`define SFC_SETUP_RST      8'h00
`define SFC_WMRK_NONE      6'h00
`define SFC_BYTE_ZERO      8'h00
`define SFC_SYS_PAD        7'h00
`define SFC_DELAY_RST      8'h00
`define SFC_DELAY_MAX      8'hFF
`define SFC_DELAY_STEP     8'h01
`define SFC_IDX_FIRST      3'h0
`define SFC_IDX_LAST       3'h4
`define SFC_IDX_STEP       3'h1
`define SFC_COUNT_ONE      6'h01
`define SFC_DEPTH          32
`define SFC_FULL_COUNT     6'h20
`define SFC_SAMPLE_W       40

`endif

// ===== sfc_pkg.sv
/*
  Types shared by the sample buffer control block.
  Assumes sfc_map.svh supplies all numeric constants.
*/
package sfc_pkg;
  typedef logic [1:0]  sfc_mode_t;
  typedef logic [5:0]  sfc_count_t;
  typedef logic [39:0] sfc_sample_t;
  typedef logic [7:0]  sfc_byte_t;
endpackage

// ===== sfc_fifo.sv
/*
  Parameterised sample FIFO with valid/ready on both sides and flush.
  Assumes one clock; a pop and a push in the same cycle are both honoured.
*/
`timescale 1ns/1ps
`include "sfc_map.svh"

module sfc_fifo #(
  parameter int WIDTH = `SFC_SAMPLE_W,
  parameter int DEPTH = `SFC_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_arst_n,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data,
  // Control and level
  input  wire logic             i_flush,
  output logic      [CW-1:0]    o_count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // A full FIFO still takes a word when the drain pops in the same cycle
  assign o_in_ready  = (o_count != CW'(DEPTH)) || i_out_ready;
  assign o_out_valid = (o_count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = o_count;
    if (i_flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (push) begin
        next_wr_ptr = AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        next_rd_ptr = AW'(rd_ptr + 1'b1);
      end
      next_count = CW'(o_count + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_count <= '0;
    end else begin
      wr_ptr  <= next_wr_ptr;
      rd_ptr  <= next_rd_ptr;
      o_count <= next_count;
    end
  end

  // Storage holds no reset; the count guards every read
  always_ff @(posedge i_mclk) begin
    if (push && !i_flush) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  a_count_bound: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_count <= CW'(DEPTH)) else $error("fifo count above depth");
  a_flush_empty: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    i_flush |=> (o_count == '0)) else $error("fifo not empty after flush");

endmodule // sfc_fifo

// ===== sfc_delay_ctr.sv
/*
  Eight-bit tick counter for the buffer delay register.
  Assumes i_tick is a one-cycle pulse per acquisition period.
*/
`timescale 1ns/1ps
`include "sfc_map.svh"

module sfc_delay_ctr (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic       i_tick,
  input  wire logic       i_clear,
  // Value
  output logic      [7:0] o_value
);
  logic       run;
  logic       next_run;
  logic [7:0] next_value;

  always_comb begin
    next_run   = run;
    next_value = o_value;
    if (i_start) begin
      next_run = 1'b1;
    end
    // Saturates rather than wrapping, so a long idle never reads as short
    if (run && i_tick && (o_value != `SFC_DELAY_MAX)) begin
      next_value = o_value + `SFC_DELAY_STEP;
    end
    if (i_clear) begin
      next_run   = 1'b0;
      next_value = `SFC_DELAY_RST;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run     <= 1'b0;
      o_value <= `SFC_DELAY_RST;
    end else begin
      run     <= next_run;
      o_value <= next_value;
    end
  end

  a_delay_clear: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    i_clear |=> (o_value == `SFC_DELAY_RST)) else $error("delay not cleared");
  a_delay_idle: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!run && !i_start) |=> $stable(o_value) || (o_value == `SFC_DELAY_RST))
    else $error("delay moved while stopped");

endmodule // sfc_delay_ctr

// ===== sfc_fifo_control.sv
/*
  Sample buffer control: overflow modes, watermark, flush, pop-on-read
  data port, delay tick counter and system mode readback.
  Assumes a byte register port driven by the serial slave, one read or
  write strobe per cycle, and an acquisition tick with its sample.
*/
`timescale 1ns/1ps
`include "sfc_map.svh"

// Summary of operation
// - Passing the watermark never stops sample acceptance.
// - One sample is pushed per acquisition tick.
// - Each data byte read returns oldest sample; sample leaves after its bytes.
// - Mode bits 7:6: 00 off, 01 circular, 10 stop-when-full, 11 unused.
// - Circular mode drops the oldest sample when full and stores the new one.
// - Stop mode refuses samples while full.
// - Buffer is flushed while disabled and on standby-to-active change.
// - Writing mode 00 clears overflow, watermark flag and count.
// - Overflow flag set when count reaches 32.
// - Watermark bits 5:0; flag raised when count equals watermark.
// - Watermark zero suppresses the watermark flag.
// - Mode field is writable in active operation.
// - Watermark field is writable in standby operation.
// - No direct change between circular and stop modes.
// - Eight-bit delay counts ticks, starting on overflow or wrap.
// - Delay returns to zero when the last buffered byte is read.
// - System mode reads standby 0, active 1 in bit 0; bits 7:1 zero.
// - Depth 32; sample bytes: pressure high, mid, low, temperature high, low.
// - When enabled, data reads at pressure-high; other output bytes read zero.
module sfc_fifo_control
  import sfc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // Acquisition
  input  wire logic        i_sample_tick,
  input  wire logic [39:0] i_sample_data,
  output logic             o_sample_ready,
  // System mode
  input  wire logic        i_active,
  // Status
  output logic             o_overflow_flag,
  output logic             o_watermark_hit_flag,
  output logic      [5:0]  o_stored_sample_count,
  output logic             o_buffer_enabled
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sfc_mode_t   mode;
  sfc_mode_t   next_mode;
  sfc_count_t  sample_watermark;
  sfc_count_t  next_watermark;
  logic [2:0]  byte_idx;
  logic [2:0]  next_byte_idx;
  logic        active_q;
  logic        next_overflow;
  logic        next_wmrk_hit;
  sfc_byte_t   next_rdata;
  sfc_mode_t   wr_mode;
  logic        wr_setup;
  logic        mode_ok;
  logic        flush;
  logic        in_valid;
  logic        in_ready;
  logic        full;
  logic        drop;
  logic        data_read;
  logic        host_pop;
  logic        last_byte_out;
  logic        out_valid;
  sfc_sample_t head;
  sfc_byte_t   head_byte;
  sfc_count_t  count;
  logic [7:0]  delay_tick_value;

  // ----------------------------------------------------------------
  // Mode decode and write acceptance
  // ----------------------------------------------------------------
  // Code 11 is not enabled, so it neither stores nor flags
  assign o_buffer_enabled = (mode == `SFC_MODE_CIRC) || (mode == `SFC_MODE_STOP);
  assign wr_setup = i_reg_wr && (i_reg_addr == `SFC_ADDR_SETUP);
  assign wr_mode  = i_reg_wdata[`SFC_MODE_MSB:`SFC_MODE_LSB];
  // Software must pass through 00 or 11 to change between circular and stop; a direct swap is dropped
  assign mode_ok  = !(((mode == `SFC_MODE_CIRC) && (wr_mode == `SFC_MODE_STOP)) ||
                      ((mode == `SFC_MODE_STOP) && (wr_mode == `SFC_MODE_CIRC)));

  always_comb begin
    next_mode      = mode;
    next_watermark = sample_watermark;
    if (wr_setup && mode_ok) begin
      next_mode = wr_mode;
    end
    if (wr_setup && !i_active) begin
      next_watermark = i_reg_wdata[`SFC_WMRK_MSB:`SFC_WMRK_LSB];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode             <= `SFC_MODE_OFF;
      sample_watermark <= `SFC_WMRK_NONE;
      active_q         <= 1'b0;
    end else begin
      mode             <= next_mode;
      sample_watermark <= next_watermark;
      active_q         <= i_active;
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  assign flush    = !o_buffer_enabled || (i_active && !active_q);
  assign full     = (count == `SFC_FULL_COUNT);
  assign in_valid = i_sample_tick && o_buffer_enabled;
  // Circular wrap pops the head in the same cycle the new sample lands
  assign drop     = in_valid && full && (mode == `SFC_MODE_CIRC);
  assign o_sample_ready = o_buffer_enabled && in_ready;

  sfc_fifo #(
    .WIDTH (`SFC_SAMPLE_W),
    .DEPTH (`SFC_DEPTH),
    .CW    (6)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (in_valid),
    .o_in_ready  (in_ready),
    .i_in_data   (i_sample_data),
    .o_out_valid (out_valid),
    .i_out_ready (host_pop || drop),
    .o_out_data  (head),
    .i_flush     (flush),
    .o_count     (count)
  );

  assign o_stored_sample_count = count;

  // ----------------------------------------------------------------
  // Data read port
  // ----------------------------------------------------------------
  assign data_read = i_reg_rd && ((i_reg_addr == `SFC_ADDR_BUF_DATA) ||
                     ((i_reg_addr == `SFC_ADDR_PRESS_HI) && o_buffer_enabled));
  assign last_byte_out = (byte_idx == `SFC_IDX_LAST);
  assign host_pop  = data_read && out_valid && last_byte_out && !flush;

  always_comb begin
    unique case (byte_idx)
      3'h0:    head_byte = head[39:32];
      3'h1:    head_byte = head[31:24];
      3'h2:    head_byte = head[23:16];
      3'h3:    head_byte = head[15:8];
      3'h4:    head_byte = head[7:0];
      default: head_byte = `SFC_BYTE_ZERO;
    endcase
  end

  always_comb begin
    next_byte_idx = byte_idx;
    if (flush || drop) begin
      // A dropped head invalidates a half-read sample; restart on the new head
      next_byte_idx = `SFC_IDX_FIRST;
    end else if (data_read && out_valid) begin
      next_byte_idx = last_byte_out ? `SFC_IDX_FIRST : byte_idx + `SFC_IDX_STEP;
    end
  end

  always_comb begin
    next_rdata = `SFC_BYTE_ZERO;
    if (data_read) begin
      next_rdata = out_valid ? head_byte : `SFC_BYTE_ZERO;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `SFC_ADDR_SETUP:   next_rdata = {mode, sample_watermark};
        `SFC_ADDR_DELAY:   next_rdata = delay_tick_value;
        `SFC_ADDR_SYSMODE: next_rdata = {`SFC_SYS_PAD, i_active};
        default:           next_rdata = `SFC_BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_comb begin
    next_overflow = o_buffer_enabled && full;
    next_wmrk_hit = o_buffer_enabled && (sample_watermark != `SFC_WMRK_NONE) &&
                    (count == sample_watermark);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      byte_idx             <= `SFC_IDX_FIRST;
      o_reg_rdata          <= `SFC_BYTE_ZERO;
      o_overflow_flag      <= 1'b0;
      o_watermark_hit_flag <= 1'b0;
    end else begin
      byte_idx             <= next_byte_idx;
      o_reg_rdata          <= next_rdata;
      o_overflow_flag      <= next_overflow;
      o_watermark_hit_flag <= next_wmrk_hit;
    end
  end

  // ----------------------------------------------------------------
  // Delay tick counter
  // ----------------------------------------------------------------
  sfc_delay_ctr u_delay (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_start  (in_valid && full),
    .i_tick   (i_sample_tick),
    .i_clear  (flush || (host_pop && (count == `SFC_COUNT_ONE))),
    .o_value  (delay_tick_value)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wmrk_flag_set: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_buffer_enabled && (sample_watermark != `SFC_WMRK_NONE) && (count == sample_watermark))
    |=> o_watermark_hit_flag) else $error("watermark flag missed");
  a_wmrk_zero_quiet: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_watermark_hit_flag |-> ($past(sample_watermark) != `SFC_WMRK_NONE))
    else $error("watermark flag with zero watermark");
  a_ovf_at_full: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_buffer_enabled && full) |=> o_overflow_flag) else $error("overflow flag missed");
  a_disable_clears: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (wr_setup && (wr_mode == `SFC_MODE_OFF)) |-> ##2
    ((count == '0) && !o_overflow_flag && !o_watermark_hit_flag))
    else $error("disable did not clear state");
  a_stop_refuse: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((mode == `SFC_MODE_STOP) && full && i_sample_tick && !host_pop && !flush)
    |=> (count == `SFC_FULL_COUNT) && $stable(head)) else $error("stop mode took sample");
  a_circ_wrap: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (drop && !host_pop && !flush) |-> o_sample_ready ##1 (count == `SFC_FULL_COUNT))
    else $error("circular wrap lost level");
  a_no_swap: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (wr_setup && (mode == `SFC_MODE_CIRC) && (wr_mode == `SFC_MODE_STOP)) |=> (mode == `SFC_MODE_CIRC))
    else $error("direct mode swap accepted");
  a_pop_one: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (host_pop && !in_valid) |=> (count == $past(count) - `SFC_COUNT_ONE))
    else $error("pop did not decrement");
  a_wake_flush: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_active && !active_q) |=> (count == '0)) else $error("no flush on wake");
  a_sysmode_read: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_reg_rd && (i_reg_addr == `SFC_ADDR_SYSMODE)) |=> (o_reg_rdata == {`SFC_SYS_PAD, $past(i_active)}))
    else $error("system mode readback wrong");
  a_tick_push: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (in_valid && !full && !host_pop && !flush) |=> (count == $past(count) + `SFC_COUNT_ONE))
    else $error("tick did not store a sample");
  a_wmrk_no_stall: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (in_valid && o_watermark_hit_flag && !full) |-> o_sample_ready)
    else $error("watermark stalled sampling");
  a_stop_swap: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (wr_setup && (mode == `SFC_MODE_STOP) && (wr_mode == `SFC_MODE_CIRC)) |=> (mode == `SFC_MODE_STOP))
    else $error("direct mode swap accepted");
  a_mode_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (wr_setup && mode_ok) |=> (mode == $past(wr_mode)))
    else $error("mode write lost");
  a_wmrk_standby_wr: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (wr_setup && !i_active) |=> (sample_watermark == $past(i_reg_wdata[`SFC_WMRK_MSB:`SFC_WMRK_LSB])))
    else $error("standby watermark write lost");
  a_unused_quiet: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((mode != `SFC_MODE_OFF) && !o_buffer_enabled) |=> (count == '0) && !o_overflow_flag && !o_watermark_hit_flag)
    else $error("unused mode stored or flagged");
  a_ovf_drop: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !full |=> !o_overflow_flag)
    else $error("overflow flag without full buffer");
  a_wmrk_level: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (count != sample_watermark) |=> !o_watermark_hit_flag)
    else $error("watermark flag held past level");
  a_other_zero: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_reg_rd && (i_reg_addr > `SFC_ADDR_PRESS_HI) && (i_reg_addr <= `SFC_ADDR_OUT_LAST)) |=> (o_reg_rdata == `SFC_BYTE_ZERO))
    else $error("other output byte not zero");
  a_empty_read: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (data_read && !out_valid) |=> (o_reg_rdata == `SFC_BYTE_ZERO))
    else $error("empty buffer read not zero");

  c_circ_wrap:  cover property (@(posedge i_mclk) disable iff (!i_arst_n) drop);
  c_stop_full:  cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    (mode == `SFC_MODE_STOP) && full && i_sample_tick);
  c_wmrk_hit:   cover property (@(posedge i_mclk) disable iff (!i_arst_n) o_watermark_hit_flag);
  c_last_drain: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    host_pop && (count == `SFC_COUNT_ONE));
  c_mode_unused: cover property (@(posedge i_mclk) disable iff (!i_arst_n)
    (mode != `SFC_MODE_OFF) && !o_buffer_enabled);

endmodule // sfc_fifo_control

// ===== sfc_host_model.sv
/*
  Host model for the sample buffer control block: byte register access
  through the block's strobe port, with single and five-byte burst reads.
  Assumes one clock; requests change on the falling edge only.
*/
`timescale 1ns/1ps

module sfc_host_model (
  // Clock
  input  wire logic       i_mclk,
  // Register port towards the block
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata
);
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // Idle address and data are inverted so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_mclk);
    o_reg_wr    = 1'b0;
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge i_mclk);
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(negedge i_mclk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    q          = i_reg_rdata;
  endtask

  // Five back-to-back reads in one burst, first byte ends up on top
  task automatic rd_sample(input logic [7:0] a, output logic [39:0] s);
    s = 40'h00_0000_0000;
    for (int i = 0; i < 5; i++) begin
      @(negedge i_mclk);
      if (i > 0) s = {s[31:0], i_reg_rdata};
      o_reg_addr = a;
      o_reg_rd   = 1'b1;
    end
    @(negedge i_mclk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    s          = {s[31:0], i_reg_rdata};
  endtask

  // Mode changes always pass through the disabled code
  task automatic set_mode(input logic [1:0] m, input logic [5:0] w);
    wr(8'h0F, {2'h0, w});
    wr(8'h0F, {m, w});
  endtask
endmodule // sfc_host_model

// ===== tb.sv
/*
  Self-checking bench for the sample buffer control block.
  Assumes the host model drives the register port; samples come from here.
*/
`timescale 1ns/1ps

module tb;
  logic        i_mclk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  o_reg_rdata;
  logic        i_sample_tick = 1'b0;
  logic [39:0] i_sample_data = 40'h00_0000_0000;
  logic        i_active = 1'b0;
  logic        o_sample_ready;
  logic        o_overflow_flag;
  logic        o_watermark_hit_flag;
  logic [5:0]  o_stored_sample_count;
  logic        o_buffer_enabled;
  int          num_errors = 0;
  int          checks_done = 0;
  logic [39:0] q[$];
  logic [39:0] s;
  logic [7:0]  b;

  always #2.5 i_mclk = ~i_mclk;

  sfc_fifo_control u_dut (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_sample_tick(i_sample_tick), .i_sample_data(i_sample_data), .o_sample_ready(o_sample_ready),
    .i_active(i_active), .o_overflow_flag(o_overflow_flag), .o_watermark_hit_flag(o_watermark_hit_flag),
    .o_stored_sample_count(o_stored_sample_count), .o_buffer_enabled(o_buffer_enabled));

  sfc_host_model u_host (
    .i_mclk(i_mclk), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_wdata(reg_wdata), .i_reg_rdata(o_reg_rdata));

  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic nc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, b);
    chk("register", e, b);
  endtask

  // Tick then one extra cycle so count and flags have both settled
  task automatic tick(input int k);
    @(negedge i_mclk);
    i_sample_tick = 1'b1;
    i_sample_data = 40'h01_0203_0400 + 40'(k);
    @(negedge i_mclk);
    i_sample_tick = 1'b0;
    i_sample_data = ~i_sample_data;
    nc(1);
  endtask

  task automatic push(input int k, input bit circ);
    if (q.size() < 32) q.push_back(40'h01_0203_0400 + 40'(k));
    else if (circ) begin
      void'(q.pop_front());
      q.push_back(40'h01_0203_0400 + 40'(k));
    end
    tick(k);
  endtask

  task automatic pop_chk(input logic [7:0] a);
    u_host.rd_sample(a, s);
    chk("sample", q.pop_front(), s);
    nc(1);
  endtask

  initial begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    nc(6);
    i_arst_n = 1'b1;
    // ----------------------------------------------------------------
    // Reset values and readback
    // ----------------------------------------------------------------
    rchk(8'h0F, 8'h00);
    rchk(8'h10, 8'h00);
    rchk(8'h11, 8'h00);
    rchk(8'h20, 8'h00);
    u_host.wr(8'h0F, 8'h43);
    rchk(8'h0F, 8'h43);
    chk("enabled", 1, o_buffer_enabled);
    i_active = 1'b1;
    nc(2);
    rchk(8'h11, 8'h01);
    // ----------------------------------------------------------------
    // Watermark equality and pop on read
    // ----------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      push(k, 1);
      chk("wmark", k == 2, o_watermark_hit_flag);
    end
    chk("count", 4, o_stored_sample_count);
    rchk(8'h02, 8'h00);
    pop_chk(8'h01);
    chk("count", 3, o_stored_sample_count);
    chk("wmark", 1, o_watermark_hit_flag);
    u_host.wr(8'h0F, 8'h45);
    rchk(8'h0F, 8'h43);
    // ----------------------------------------------------------------
    // Circular wrap, delay counter
    // ----------------------------------------------------------------
    for (int k = 4; k < 36; k++) push(k, 1);
    chk("count", 32, o_stored_sample_count);
    chk("ovf", 1, o_overflow_flag);
    u_host.rd(8'h10, b);
    chk("delay", 8'h02, b);
    pop_chk(8'h0E);
    while (q.size() > 0) pop_chk(8'h0E);
    rchk(8'h10, 8'h00);
    chk("count", 0, o_stored_sample_count);
    chk("ovf", 0, o_overflow_flag);
    rchk(8'h0E, 8'h00);
    // ----------------------------------------------------------------
    // Disable flushes, unused code acts disabled
    // ----------------------------------------------------------------
    push(39, 1);
    push(40, 1);
    push(41, 1);
    chk("wmark", 1, o_watermark_hit_flag);
    u_host.wr(8'h0F, 8'h03);
    nc(1);
    chk("count", 0, o_stored_sample_count);
    chk("wmark", 0, o_watermark_hit_flag);
    chk("enabled", 0, o_buffer_enabled);
    tick(42);
    chk("count", 0, o_stored_sample_count);
    chk("ready", 0, o_sample_ready);
    u_host.wr(8'h0F, 8'hC3);
    tick(43);
    chk("count", 0, o_stored_sample_count);
    chk("ovf", 0, o_overflow_flag);
    rchk(8'h0F, 8'hC3);
    q.delete();
    // ----------------------------------------------------------------
    // Zero watermark, standby to active flush
    // ----------------------------------------------------------------
    i_active = 1'b0;
    u_host.set_mode(2'h1, 6'h00);
    i_active = 1'b1;
    nc(2);
    for (int k = 0; k < 3; k++) begin
      chk("wmark", 0, o_watermark_hit_flag);
      push(k, 1);
    end
    chk("count", 3, o_stored_sample_count);
    i_active = 1'b0;
    nc(2);
    i_active = 1'b1;
    nc(2);
    chk("count", 0, o_stored_sample_count);
    q.delete();
    // ----------------------------------------------------------------
    // Stop-when-full, refused direct mode swap
    // ----------------------------------------------------------------
    u_host.set_mode(2'h2, 6'h00);
    rchk(8'h0F, 8'h80);
    for (int k = 0; k < 33; k++) push(k, 0);
    chk("count", 32, o_stored_sample_count);
    chk("ovf", 1, o_overflow_flag);
    chk("ready", 0, o_sample_ready);
    u_host.wr(8'h0F, 8'h40);
    rchk(8'h0F, 8'h80);
    pop_chk(8'h01);
    chk("count", 31, o_stored_sample_count);
    push(50, 0);
    chk("count", 32, o_stored_sample_count);
    give_verdict();
  end
endmodule // tb
